// File: verilog/tp10_defines.svh
// Constants for the 10 Mbit/s twisted-pair PHY control block
`ifndef TP10_DEFINES_SVH
`define TP10_DEFINES_SVH
// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CLK_NS 20
`define SQ_WIN_NS 150
`define EOP_NS 200
`define CRS_DROP_NS 150
`define SQE_DLY_NS 1000
`define SQE_LEN_NS 1000
`define LP_LEN_NS 100
`define US_NS 1000
// Longest times round down, least times round up
`define SQ_WIN_CYC (`SQ_WIN_NS / `CLK_NS)
`define EOP_CYC ((`EOP_NS + `CLK_NS - 1) / `CLK_NS)
`define CRS_DROP_CYC (`CRS_DROP_NS / `CLK_NS)
`define SQE_DLY_CYC (`SQE_DLY_NS / `CLK_NS)
`define SQE_END_CYC (`SQE_DLY_CYC + (`SQE_LEN_NS / `CLK_NS))
`define LP_LEN_CYC (`LP_LEN_NS / `CLK_NS)
`define US_CYC (`US_NS / `CLK_NS)
`define JAB_US 24000
`define UNJAB_US 256000
`define LP_US 16000
`define LOSS_US 100000
// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
`define REG_STAT1 5'h01
`define REG_CTL 5'h10
`define REG_CFG10 5'h1a
`define REG_STAT10 5'h1c
`define STAT1_LINK 2
`define CFG_POL_DIS 3
`define CFG_JAB_DIS 10
`define CFG_LONG 11
`define CFG_SQE_DIS 12
`define CFG_MASK 16'h1c08
`define CTL_FDX 0
`define ST10_LINK 0
`define ST10_JAB 1
`define ST10_POL 15
`define CFG_RST 16'h0000
`endif

// File: verilog/tp10_pkg.sv
// Types for the 10 Mbit/s twisted-pair PHY control block
package tp10_pkg;
    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_ARM1 = 2'b01,
        SQ_ARM2 = 2'b10,
        SQ_VALID = 2'b11
    } sq_st_t;

    typedef struct packed {
        logic [1:0] txs;
        logic [1:0] sqp;
        logic [1:0] sqn;
        logic [2:0] mid;
        logic [2:0] lpp;
        logic [1:0] lpi;
        logic [1:0] eopi;
        sq_st_t sq;
        logic sq_low;
        logic sq_first;
        logic [3:0] sq_cnt;
        logic [3:0] mid_cnt;
        logic [5:0] pre;
        logic [19:0] jab_cnt;
        logic jab;
        logic [19:0] lp_cnt;
        logic [2:0] lpw;
        logic [19:0] loss_cnt;
        logic link;
        logic [6:0] sqe_cnt;
        logic [2:0] lp_inv_n;
        logic [1:0] eop_n;
        logic pol;
        logic last_bit;
        logic tx_on;
        logic stop;
        logic end_mid;
        logic crs;
        logic col;
        logic lp_out;
        logic [15:0] cfg;
        logic fdx;
        logic [15:0] rdata;
    } st_t;
endpackage

// File: verilog/tp10_phy.sv
// 10 Mbit/s twisted-pair PHY digital control: squelch, CRS, COL, jabber
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
`include "tp10_defines.svh"
// How it works
// - Half duplex: COL reports, CRS on tx/rx
// - Full duplex: tx and rx run independently
// - Send from TX_EN rise while link good
// - Last transition mid-cell for one, boundary zero
// - No mid-bit transitions ends frame, CRS drops
// - Squelch: threshold, opposite, original within windows
// - Packet ends after 200 ns squelch silence
// - Reduced squelch thresholds while data valid
// - Long-cable bit lowers receive squelch threshold
// - CRS from rx; tx too in half duplex
// - Half duplex: rx and tx together raise COL
// - SQE pulse on COL after each packet
// - SQE off by config bit or full duplex
// - TX_EN over 24 ms jabbers, COL high
// - Unjab after 256 ms of TX_EN low
// - Config bit turns jabber lockout off
// - No link: tx, rx, collision disabled; jabber can still raise COL
// - Idle line: 100 ns link pulse, 16 ms
// - Seven link pulses or three packets invert
// - Config bit disables polarity correction
// - Link bit merges 10 and 100 link
module tp10_phy import tp10_pkg::*; #(
    parameter int unsigned JAB_US = `JAB_US,
    parameter int unsigned UNJAB_US = `UNJAB_US,
    parameter int unsigned LP_US = `LP_US,
    parameter int unsigned LOSS_US = `LOSS_US
) (
    input wire logic i_clk, // 50 MHz clock
    input wire logic i_nrst, // Async reset, active low
    input wire logic [4:0] i_addr, // Register address
    input wire logic [15:0] i_wdata, // Register write data
    input wire logic i_we, // Write strobe
    input wire logic i_re, // Read strobe
    output logic [15:0] o_rdata, // Read data, cycle after i_re
    input wire logic i_tx_en, // MAC transmit enable
    input wire logic i_tx_bit, // Current encoder bit
    input wire logic i_sq_pos, // Positive squelch crossed
    input wire logic i_sq_neg, // Negative squelch crossed
    input wire logic i_rx_lvl, // Receive comparator level
    input wire logic i_lp_rx, // Received link pulse
    input wire logic i_lp_inv, // Link pulse seen inverted
    input wire logic i_eop_inv, // End pulse seen inverted
    input wire logic i_link100, // 100 Mbit/s link good
    output logic o_crs, // Carrier sense
    output logic o_col, // Collision
    output logic o_tx_on, // Transmitter enabled
    output logic o_tx_stop, // End of transmission pulse
    output logic o_end_mid, // Final transition at mid-cell
    output logic o_lp_out, // Link pulse drive
    output logic o_sq_low, // Reduced squelch thresholds
    output logic o_long_cable, // Lowered squelch threshold
    output logic o_pol_inv // Receive polarity corrected
);
    st_t s;
    st_t n;
    logic tick;
    logic tx_act;
    logic rx_act;
    logic sp;
    logic sn;
    logic lp_rise;
    logic mid_ev;
    logic sqe_ok;

    // Squelch level expected next, given the one seen first
    function automatic logic opp(input logic first, input logic p,
                                 input logic q);
        opp = first ? q : p;
    endfunction

    assign tick = (s.pre == 6'(`US_CYC - 1));
    assign sp = s.sqp[1];
    assign sn = s.sqn[1];
    assign lp_rise = s.lpp[1] & ~s.lpp[2];
    assign mid_ev = s.mid[1] ^ s.mid[2];
    assign tx_act = s.txs[1] & s.link & ~s.jab;
    assign rx_act = (s.sq == SQ_VALID) & s.link;
    assign sqe_ok = ~s.fdx & ~s.cfg[`CFG_SQE_DIS];

    always_comb begin
        n = s;
        // ------------------------------------------------------------
        // Synchronisers
        // ------------------------------------------------------------
        n.txs = {s.txs[0], i_tx_en};
        n.sqp = {s.sqp[0], i_sq_pos};
        n.sqn = {s.sqn[0], i_sq_neg};
        n.mid = {s.mid[1:0], i_rx_lvl};
        n.lpp = {s.lpp[1:0], i_lp_rx};
        n.lpi = {s.lpi[0], i_lp_inv};
        n.eopi = {s.eopi[0], i_eop_inv};
        n.pre = tick ? 6'h00 : s.pre + 6'h01;
        // ------------------------------------------------------------
        // Smart squelch
        // ------------------------------------------------------------
        case (s.sq)
            SQ_IDLE: begin
                if (sp | sn) begin
                    n.sq_first = sp;
                    n.sq_cnt = 4'h0;
                    n.sq = SQ_ARM1;
                end
            end
            SQ_ARM1: begin
                n.sq_cnt = s.sq_cnt + 4'h1;
                if (opp(s.sq_first, sp, sn)) begin
                    n.sq_cnt = 4'h0;
                    n.sq = SQ_ARM2;
                end else if (s.sq_cnt >= 4'(`SQ_WIN_CYC - 1)) begin
                    n.sq = SQ_IDLE;
                end
            end
            SQ_ARM2: begin
                n.sq_cnt = s.sq_cnt + 4'h1;
                if (opp(s.sq_first, sn, sp)) begin
                    n.sq_cnt = 4'h0;
                    n.mid_cnt = 4'h0;
                    n.sq = SQ_VALID;
                end else if (s.sq_cnt >= 4'(`SQ_WIN_CYC - 1)) begin
                    n.sq = SQ_IDLE;
                end
            end
            SQ_VALID: begin
                n.sq_cnt = (sp | sn) ? 4'h0 : s.sq_cnt + 4'h1;
                n.mid_cnt = mid_ev ? 4'h0 : s.mid_cnt + 4'h1;
                // Squelch silence or lost mid-bit transitions end it
                if (s.sq_cnt >= 4'(`EOP_CYC) ||
                    s.mid_cnt >= 4'(`CRS_DROP_CYC)) begin
                    n.sq = SQ_IDLE;
                    if (!s.cfg[`CFG_POL_DIS]) begin
                        n.eop_n = s.eopi[1] ? s.eop_n + 2'h1 : 2'h0;
                        if (s.eopi[1] && s.eop_n == 2'h2) begin
                            n.pol = 1'b1;
                        end
                    end
                end
            end
            default: n.sq = SQ_IDLE;
        endcase
        n.sq_low = (n.sq == SQ_VALID);
        // ------------------------------------------------------------
        // Link integrity and link pulses
        // ------------------------------------------------------------
        if (lp_rise | rx_act) begin
            n.loss_cnt = 20'h00000;
            n.link = 1'b1;
        end else if (tick) begin
            if (s.loss_cnt >= 20'(LOSS_US - 1)) begin
                n.link = 1'b0;
            end else begin
                n.loss_cnt = s.loss_cnt + 20'h00001;
            end
        end
        if (tx_act) begin
            n.lp_cnt = 20'h00000;
            n.lpw = 3'h0;
        end else begin
            if (s.lpw != 3'h0) begin
                n.lpw = s.lpw - 3'h1;
            end
            if (tick) begin
                if (s.lp_cnt >= 20'(LP_US - 1)) begin
                    n.lp_cnt = 20'h00000;
                    n.lpw = 3'(`LP_LEN_CYC);
                end else begin
                    n.lp_cnt = s.lp_cnt + 20'h00001;
                end
            end
        end
        n.lp_out = (n.lpw != 3'h0);
        // ------------------------------------------------------------
        // Polarity detection from link pulses
        // ------------------------------------------------------------
        if (s.cfg[`CFG_POL_DIS]) begin
            n.pol = 1'b0;
            n.lp_inv_n = 3'h0;
            n.eop_n = 2'h0;
        end else if (lp_rise) begin
            n.lp_inv_n = s.lpi[1] ? s.lp_inv_n + 3'h1 : 3'h0;
            if (s.lpi[1] && s.lp_inv_n == 3'h6) begin
                n.pol = 1'b1;
            end
        end
        // ------------------------------------------------------------
        // Jabber: the unjab wait restarts whenever TX_EN rises again
        // ------------------------------------------------------------
        if (s.cfg[`CFG_JAB_DIS]) begin
            n.jab = 1'b0;
            n.jab_cnt = 20'h00000;
        end else if (!s.jab) begin
            if (!s.txs[1]) begin
                n.jab_cnt = 20'h00000;
            end else if (tick) begin
                n.jab_cnt = s.jab_cnt + 20'h00001;
                if (s.jab_cnt >= 20'(JAB_US)) begin
                    n.jab = 1'b1;
                    n.jab_cnt = 20'h00000;
                end
            end
        end else begin
            if (s.txs[1]) begin
                n.jab_cnt = 20'h00000;
            end else if (tick) begin
                n.jab_cnt = s.jab_cnt + 20'h00001;
                if (s.jab_cnt >= 20'(UNJAB_US - 1)) begin
                    n.jab = 1'b0;
                    n.jab_cnt = 20'h00000;
                end
            end
        end
        // ------------------------------------------------------------
        // Transmit start and stop
        // ------------------------------------------------------------
        n.tx_on = tx_act;
        n.stop = s.tx_on & ~tx_act;
        if (tx_act) begin
            n.last_bit = i_tx_bit;
        end
        n.end_mid = (s.tx_on & ~tx_act) ? s.last_bit : 1'b0;
        // ------------------------------------------------------------
        // SQE test pulse
        // ------------------------------------------------------------
        if (s.stop & sqe_ok) begin
            n.sqe_cnt = 7'h01;
        end else if (!sqe_ok || s.sqe_cnt == 7'(`SQE_END_CYC)) begin
            n.sqe_cnt = 7'h00;
        end else if (s.sqe_cnt != 7'h00) begin
            n.sqe_cnt = s.sqe_cnt + 7'h01;
        end
        // ------------------------------------------------------------
        // Carrier sense and collision
        // ------------------------------------------------------------
        n.crs = rx_act | (~s.fdx & tx_act);
        n.col = (~s.fdx & rx_act & tx_act) | s.jab |
                (s.sqe_cnt > 7'(`SQE_DLY_CYC));
        // ------------------------------------------------------------
        // Register port
        // ------------------------------------------------------------
        n.rdata = 16'h0000;
        if (i_we) begin
            case (i_addr)
                `REG_CFG10: n.cfg = i_wdata & `CFG_MASK;
                `REG_CTL: n.fdx = i_wdata[`CTL_FDX];
                default: n.cfg = s.cfg;
            endcase
        end
        if (i_re) begin
            case (i_addr)
                `REG_STAT1:
                    n.rdata[`STAT1_LINK] = s.link | i_link100;
                `REG_CTL: n.rdata[`CTL_FDX] = s.fdx;
                `REG_CFG10: n.rdata = s.cfg;
                `REG_STAT10: begin
                    n.rdata[`ST10_POL] = s.pol;
                    n.rdata[`ST10_JAB] = s.jab;
                    n.rdata[`ST10_LINK] = s.link;
                end
                default: n.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign o_rdata = s.rdata;
    assign o_crs = s.crs;
    assign o_col = s.col;
    assign o_tx_on = s.tx_on;
    assign o_tx_stop = s.stop;
    assign o_end_mid = s.end_mid;
    assign o_lp_out = s.lp_out;
    assign o_sq_low = s.sq_low;
    assign o_long_cable = s.cfg[`CFG_LONG];
    assign o_pol_inv = s.pol;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    property p_crs; rx_act |=> o_crs; endproperty
    a_crs: assert property (p_crs) else $error("crs missing");
    property p_col;
        !s.fdx && rx_act && tx_act |=> o_col;
    endproperty
    a_col: assert property (p_col) else $error("col missing");
    property p_fdx;
        s.fdx && !s.jab && s.sqe_cnt <= 7'(`SQE_DLY_CYC) |=> !o_col;
    endproperty
    a_fdx: assert property (p_fdx) else $error("fdx col");
    property p_end;
        s.tx_on && !tx_act |=> o_tx_stop && o_end_mid == $past(s.last_bit);
    endproperty
    a_end: assert property (p_end) else $error("bad end");
    property p_sq;
        $rose(o_sq_low) |-> $past(s.sq) == SQ_ARM2;
    endproperty
    a_sq: assert property (p_sq) else $error("unqualified rx");
    property p_eop;
        s.sq == SQ_VALID && s.sq_cnt >= 4'(`EOP_CYC) |=> !o_sq_low;
    endproperty
    a_eop: assert property (p_eop) else $error("eop late");
    property p_sqe;
        s.stop && sqe_ok |-> ##52 o_col;
    endproperty
    a_sqe: assert property (p_sqe) else $error("sqe missing");
    // A jabber stop keeps TX_EN high and COL held, so only clean ends
    property p_sqe_gap;
        s.stop && sqe_ok && !s.txs[1] |-> ##51 !o_col ##1 o_col ##50 !o_col;
    endproperty
    a_sqe_gap: assert property (p_sqe_gap) else $error("sqe timing");
    property p_nosqe; !sqe_ok |=> s.sqe_cnt == 7'h00; endproperty
    a_nosqe: assert property (p_nosqe) else $error("sqe on");
    property p_jab; s.jab |=> o_col && !o_tx_on; endproperty
    a_jab: assert property (p_jab) else $error("jabber");
    property p_link; !s.link |=> !o_crs && !o_tx_on; endproperty
    a_link: assert property (p_link) else $error("no link");
    property p_pol; s.cfg[`CFG_POL_DIS] |=> !o_pol_inv; endproperty
    a_pol: assert property (p_pol) else $error("pol on");
    property p_mid;
        s.sq == SQ_VALID && s.mid_cnt >= 4'(`CRS_DROP_CYC) |=> !o_sq_low;
    endproperty
    a_mid: assert property (p_mid) else $error("mid end late");
    property p_lp; o_lp_out |-> !o_tx_on; endproperty
    a_lp: assert property (p_lp) else $error("pulse in frame");
    property p_stop; o_tx_stop |=> !o_tx_stop; endproperty
    a_stop: assert property (p_stop) else $error("long stop");
    c_rx: cover property (rx_act ##1 !rx_act);
    c_colr: cover property (o_col && o_crs && o_tx_on);
    c_lp: cover property ($rose(o_lp_out));
    c_sqe: cover property (s.stop ##52 o_col);
endmodule

// File: tb/tp10_mac_model.sv
// MAC-side model: raises transmit enable for a commanded number of cycles
`timescale 1ns/1ns
module tp10_mac_model (
    input wire logic i_clk, // Bench clock
    input wire logic i_go, // Start a frame, one cycle
    input wire logic [15:0] i_len, // Frame length in cycles
    input wire logic i_last, // Value of the final bit
    output logic o_tx_en, // Transmit enable to the PHY
    output logic o_tx_bit // Encoder bit to the PHY
);
// ----------------------------------------------------------------
// Frame timer
// ----------------------------------------------------------------
logic [15:0] cnt_r = '0;
always @(posedge i_clk) begin
    if (i_go && cnt_r == 16'h0000) begin
        cnt_r <= i_len;
    end else if (cnt_r != 16'h0000) begin
        cnt_r <= cnt_r - 16'h0001;
    end
end
// Enable drops only between commands, giving the unjab wait its idle time
assign o_tx_en = cnt_r != 16'h0000;
// Final bits held steady, since the PHY samples them after a sync delay
assign o_tx_bit = (cnt_r > 16'h0004) ? cnt_r[0] : i_last;
endmodule

// File: tb/tp10_phy_tb.sv
// Self-checking bench for the 10 Mbit/s twisted-pair PHY control block
`timescale 1ns/1ns
`include "tp10_defines.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tp10_phy_tb import tp10_pkg::*; ;
logic clk = 0, nrst = 0, we = 0, re = 0, go = 0, last = 0;
logic [4:0] addr = '0;
logic [15:0] wdata = '0, len = '0, d, rdata;
logic sq_pos = 0, sq_neg = 0, rx_lvl = 0, lp_rx = 0, lp_inv = 0, eop_inv = 0;
logic link100 = 0, tx_en, tx_bit, crs, col, tx_on, tx_stop, end_mid;
logic lp_out, sq_low, long_cable, pol_inv;
int fails = 0, total_checks = 0, cyc = 0, n, w;
always #10 clk = ~clk;
tp10_phy #(.JAB_US(20), .UNJAB_US(40), .LP_US(10), .LOSS_US(30)) i_dut (
    .i_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_we(we),
    .i_re(re), .o_rdata(rdata), .i_tx_en(tx_en), .i_tx_bit(tx_bit),
    .i_sq_pos(sq_pos), .i_sq_neg(sq_neg), .i_rx_lvl(rx_lvl),
    .i_lp_rx(lp_rx), .i_lp_inv(lp_inv), .i_eop_inv(eop_inv),
    .i_link100(link100), .o_crs(crs), .o_col(col), .o_tx_on(tx_on),
    .o_tx_stop(tx_stop), .o_end_mid(end_mid), .o_lp_out(lp_out),
    .o_sq_low(sq_low), .o_long_cable(long_cable), .o_pol_inv(pol_inv));
tp10_mac_model i_mac (.i_clk(clk), .i_go(go), .i_len(len), .i_last(last),
    .o_tx_en(tx_en), .o_tx_bit(tx_bit));
task automatic stop_test();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
endtask
always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
        fails++;
        stop_test();
    end
end
// Far end keeps the link alive; lp_inv sets the pulse polarity
always begin
    repeat (400) @(posedge clk);
    lp_rx <= 1'b1;
    repeat (3) @(posedge clk);
    lp_rx <= 1'b0;
end
// ----------------------------------------------------------------
// Bus and line helpers
// ----------------------------------------------------------------
task automatic step();
    @(posedge clk);
    #1;
endtask
task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
endtask
task automatic rd(input logic [4:0] a);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 d = rdata;
endtask
task automatic send(input logic [15:0] l, input logic lb);
    @(posedge clk);
    len <= l;
    last <= lb;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
endtask
task automatic wait_stop();
    n = 0;
    do begin step(); n++; end while (tx_stop !== 1'b1 && n < 2000);
endtask
// Crossings alternate every two cycles, well inside both windows
task automatic rx_burst(input int cnt);
    for (int i = 0; i < cnt; i++) begin
        @(posedge clk);
        sq_pos <= (i % 4) < 2;
        sq_neg <= (i % 4) >= 2;
        rx_lvl <= ~rx_lvl;
    end
    @(posedge clk);
    sq_pos <= 1'b0;
    sq_neg <= 1'b0;
    #1;
endtask
// ----------------------------------------------------------------
// Scenarios
// ----------------------------------------------------------------
task automatic t_link_down();
    send(16'd100, 1'b0);
    n = 0;
    repeat (110) begin step(); if (tx_on !== 1'b0 || crs !== 1'b0) n++; end
    `CHK(n, 0)
    rd(`REG_STAT1);
    `CHK(d[`STAT1_LINK], 1'b0)
    @(posedge clk);
    link100 <= 1'b1;
    rd(`REG_STAT1);
    `CHK(d[`STAT1_LINK], 1'b1)
    @(posedge clk);
    link100 <= 1'b0;
    repeat (420) step();
    rd(`REG_STAT10);
    `CHK(d[`ST10_LINK], 1'b1)
endtask
task automatic t_regs();
    rd(`REG_CFG10);
    `CHK(d, `CFG_RST)
    wr(`REG_CFG10, 16'hffff);
    rd(`REG_CFG10);
    `CHK(d, `CFG_MASK)
    `CHK(long_cable, 1'b1)
    step();
    `CHK(rdata, 16'h0000)
    wr(`REG_CFG10, 16'h0000);
    rd(5'h05);
    `CHK(d, 16'h0000)
    `CHK(long_cable, 1'b0)
endtask
task automatic t_tx(input logic lb);
    send(16'd200, lb);
    n = 0;
    do begin step(); n++; end while (tx_on !== 1'b1 && n < 10);
    `CHK(crs, 1'b1)
    wait_stop();
    `CHK(tx_stop, 1'b1)
    `CHK(end_mid, lb)
    n = 0;
    do begin step(); n++; end while (col !== 1'b1 && n < 80);
    `CHK(n >= 50 && n <= 54, 1'b1)
    w = 0;
    do begin step(); w++; end while (col === 1'b1 && w < 80);
    `CHK(w, 50)
endtask
task automatic t_sqe_off(input logic fdx);
    if (fdx) wr(`REG_CTL, 16'h0001);
    else wr(`REG_CFG10, 16'h0001 << `CFG_SQE_DIS);
    send(16'd200, 1'b1);
    repeat (20) step();
    `CHK(crs, ~fdx)
    wait_stop();
    n = 0;
    repeat (120) begin step(); if (col !== 1'b0) n++; end
    `CHK(n, 0)
    wr(`REG_CTL, 16'h0000);
    wr(`REG_CFG10, 16'h0000);
endtask
task automatic t_col(input logic fdx);
    wr(`REG_CTL, {15'h0000, fdx});
    rd(`REG_CTL);
    `CHK(d[`CTL_FDX], fdx)
    send(16'd300, 1'b0);
    repeat (10) step();
    rx_burst(40);
    `CHK(col, ~fdx)
    `CHK(tx_on, 1'b1)
    wait_stop();
    repeat (150) step();
    wr(`REG_CTL, 16'h0000);
endtask
task automatic t_rx();
    @(posedge clk);
    sq_pos <= 1'b1;
    @(posedge clk);
    sq_pos <= 1'b0;
    repeat (20) step();
    `CHK(crs, 1'b0)
    rx_burst(40);
    `CHK(crs, 1'b1)
    `CHK(sq_low, 1'b1)
    repeat (16) step();
    `CHK(crs, 1'b0)
    `CHK(sq_low, 1'b0)
    // Mid-bit transitions go on; only squelch silence may end this one
    rx_burst(40);
    `CHK(crs, 1'b1)
    repeat (20) begin
        @(posedge clk);
        rx_lvl <= ~rx_lvl;
    end
    #1;
    `CHK(crs, 1'b0)
endtask
task automatic t_lp();
    n = 0;
    do begin step(); n++; end while (lp_out !== 1'b1 && n < 600);
    w = 0;
    do begin step(); w++; end while (lp_out === 1'b1 && w < 20);
    `CHK(w, `LP_LEN_CYC)
    n = 0;
    do begin step(); n++; end while (lp_out !== 1'b1 && n < 600);
    `CHK(n + w > 490 && n + w < 510, 1'b1)
endtask
task automatic t_jab(input logic dis);
    wr(`REG_CFG10, {5'h00, dis, 10'h000});
    send(16'd1500, 1'b0);
    repeat (1060) step();
    `CHK(tx_on, dis)
    `CHK(col, ~dis)
    rd(`REG_STAT10);
    `CHK(d[`ST10_JAB], ~dis)
    repeat (1500) step();
    `CHK(col, ~dis)
    repeat (1100) step();
    `CHK(col, 1'b0)
    wr(`REG_CFG10, 16'h0000);
endtask
task automatic t_pol();
    wr(`REG_CFG10, 16'h0008);
    @(posedge clk);
    lp_inv <= 1'b1;
    repeat (3300) step();
    `CHK(pol_inv, 1'b0)
    wr(`REG_CFG10, 16'h0000);
    repeat (3300) step();
    `CHK(pol_inv, 1'b1)
    rd(`REG_STAT10);
    `CHK(d[`ST10_POL], 1'b1)
    wr(`REG_CFG10, 16'h0008);
    repeat (3) step();
    `CHK(pol_inv, 1'b0)
    @(posedge clk);
    lp_inv <= 1'b0;
    eop_inv <= 1'b1;
    wr(`REG_CFG10, 16'h0000);
    for (int i = 0; i < 3; i++) begin
        `CHK(pol_inv, 1'b0)
        rx_burst(40);
        repeat (16) step();
    end
    `CHK(pol_inv, 1'b1)
endtask
initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_link_down();
    t_regs();
    t_tx(1'b0);
    t_tx(1'b1);
    t_sqe_off(1'b0);
    t_sqe_off(1'b1);
    t_col(1'b0);
    t_col(1'b1);
    t_rx();
    t_lp();
    t_jab(1'b0);
    t_jab(1'b1);
    t_pol();
    stop_test();
end
endmodule
